// *** src/urf_consts.vh ***
`ifndef URF_CONSTS_VH
`define URF_CONSTS_VH
// Register offsets
`define URF_OFS_RSTCTL      8'h10
`define URF_OFS_MODE        8'h40
`define URF_OFS_KEPT        8'h44
// Control register fields
`define URF_BIT_CORE_RST    0
`define URF_BIT_BUS_RST     1
`define URF_BIT_FRM_RST     2
`define URF_BIT_RX_FLUSH    4
`define URF_BIT_TX_FLUSH    5
`define URF_TXNUM_LSB       6
`define URF_TXNUM_MSB       10
`define URF_BIT_MST_IDLE    31
`define URF_RSTCTL_RESET    32'h8000_0000
// Flush target codes
`define URF_TXNUM_ALL       5'h10
`define URF_TXNUM_NPER      5'h00
`define URF_TXNUM_PER       5'h01
// Kept-across-core-reset register fields
`define URF_BIT_CLK_GATE    0
`define URF_BIT_CLK_STOP    1
`define URF_PHYSEL_LSB      2
`define URF_PHYSEL_MSB      3
`define URF_SPDSEL_LSB      4
`define URF_SPDSEL_MSB      5
// Timing counts in cycles
`define URF_RX_FLUSH_CYC    4'h8
`define URF_TX_FLUSH_CYC    4'h8
`define URF_CORE_RST_CYC    4'h8
`define URF_BUS_RST_CYC     4'h4
`define URF_CNT_W           4
`endif

// *** src/urf_sync2.v ***
`timescale 1ns/100ps
`default_nettype none
// Two-stage level synchroniser for pin inputs
module urf_sync2 (
	input  wire core_clk_i, // Clock
	input  wire srst_i,     // Sync reset
	input  wire d_i,        // Async level
	output wire q_o         // Synchronised level
);
	reg meta_r;
	reg sync_r;
	// First stage feeds only the second
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end else begin
			meta_r <= d_i;
			sync_r <= meta_r;
		end
	end
	assign q_o = sync_r;
endmodule // urf_sync2
`default_nettype wire

// *** src/urf_timer.v ***
`timescale 1ns/100ps
`default_nettype none
`include "urf_consts.vh"
// Self-clearing operation timer: busy from start until count expires
module urf_timer (
	input  wire                 core_clk_i, // Clock
	input  wire                 srst_i,     // Sync reset
	input  wire                 start_i,    // Begin operation
	input  wire                 hold_i,     // Stall completion
	input  wire [`URF_CNT_W-1:0] len_i,     // Cycles to run
	output wire                 busy_o,     // Operation running
	output wire                 done_o      // Completion pulse
);
	reg [`URF_CNT_W-1:0] cnt_r;
	reg                  busy_r;
	// Count down; hold keeps the last cycle pending
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			cnt_r  <= {`URF_CNT_W{1'b0}};
			busy_r <= 1'b0;
		end else if (start_i && !busy_r) begin
			cnt_r  <= len_i - 4'h1;
			busy_r <= 1'b1;
		end else if (busy_r) begin
			if (cnt_r != {`URF_CNT_W{1'b0}})
				cnt_r <= cnt_r - 4'h1;
			else if (!hold_i)
				busy_r <= 1'b0;
		end
	end
	assign busy_o = busy_r;
	assign done_o = busy_r && (cnt_r == {`URF_CNT_W{1'b0}}) && !hold_i;
endmodule // urf_timer
`default_nettype wire

// *** src/urf_core.v ***
`timescale 1ns/100ps
`default_nettype none
`include "urf_consts.vh"
module urf_core (
	input  wire        core_clk_i,     // 100 MHz clock
	input  wire        srst_i,         // Sync reset, active high
	input  wire [7:0]  reg_addr_i,     // Register byte address
	input  wire [31:0] reg_wdata_i,    // Write data
	input  wire        reg_wr_i,       // Write strobe
	input  wire        reg_rd_i,       // Read strobe
	output reg  [31:0] reg_rdata_o,    // Read data, cycle after strobe
	input  wire        host_mode_pin_i,// Mode level from ID logic
	input  wire        bus_xfer_act_i, // Bus master transfer in flight
	input  wire        usb_xact_act_i, // USB transaction in flight
	output wire        usb_abort_o,    // Abort USB transaction now
	output wire        bus_quiesce_o,  // Stop issuing bus requests
	output wire        slave_idle_o,   // Force bus slave to idle
	output wire        bus_dom_rst_o,  // Bus-domain logic reset
	output wire        phy_dom_rst_o,  // PHY-domain logic reset
	output wire        frame_cnt_clr_o,// Zero host frame counter
	output wire        rx_flush_o,     // Empty receive FIFO
	output wire [16:0] tx_flush_o,     // Empty per transmit FIFO
	output wire        clk_gate_o,     // Kept clock gating bit
	output wire        clk_stop_o,     // Kept clock stop bit
	output wire [1:0]  phy_clk_sel_o,  // Kept PHY clock select
	output wire [1:0]  spd_sel_o       // Kept device speed select
);
	// Control register state
	reg        core_rst_r;
	reg        bus_rst_r;
	reg        frm_rst_r;
	reg        rx_fl_r;
	reg        tx_fl_r;
	reg [4:0]  txnum_r;
	reg [4:0]  txnum_nxt;
	reg        kept_gate_r;
	reg        kept_stop_r;
	reg [1:0]  kept_phy_r;
	reg [1:0]  kept_spd_r;
	reg        usb_ab_r;
	reg [16:0] tx_sel_r;
	wire       host_mode;
	wire       bus_act_s;
	wire       usb_act_s;
	wire       mst_idle;
	wire       core_busy;
	wire       core_done;
	wire       bus_busy;
	wire       bus_done;
	wire       rx_busy;
	wire       rx_done;
	wire       tx_busy;
	wire       tx_done;
	wire       wr_ctl;
	wire       wr_kept;
	wire       any_rst;

	assign wr_ctl  = reg_wr_i && (reg_addr_i == `URF_OFS_RSTCTL);
	assign wr_kept = reg_wr_i && (reg_addr_i == `URF_OFS_KEPT);

	// Mode and activity levels come from outside; synchronise them
	urf_sync2 u_sync_mode (
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.d_i        (host_mode_pin_i),
		.q_o        (host_mode)
	);
	urf_sync2 u_sync_bus (
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.d_i        (bus_xfer_act_i),
		.q_o        (bus_act_s)
	);
	urf_sync2 u_sync_usb (
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.d_i        (usb_xact_act_i),
		.q_o        (usb_act_s)
	);

	// bus ends gracefully
	// Core reset waits out the current bus transfer before completing
	urf_timer u_core_tmr (
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.start_i    (core_rst_r),
		.hold_i     (bus_act_s),
		.len_i      (`URF_CORE_RST_CYC),
		.busy_o     (core_busy),
		.done_o     (core_done)
	);
	urf_timer u_bus_tmr (
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.start_i    (bus_rst_r),
		.hold_i     (1'b0),
		.len_i      (`URF_BUS_RST_CYC),
		.busy_o     (bus_busy),
		.done_o     (bus_done)
	);
	urf_timer u_rx_tmr (
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.start_i    (rx_fl_r),
		.hold_i     (1'b0),
		.len_i      (`URF_RX_FLUSH_CYC),
		.busy_o     (rx_busy),
		.done_o     (rx_done)
	);
	urf_timer u_tx_tmr (
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.start_i    (tx_fl_r),
		.hold_i     (1'b0),
		.len_i      (`URF_TX_FLUSH_CYC),
		.busy_o     (tx_busy),
		.done_o     (tx_done)
	);

	assign any_rst = srst_i || core_done;

	// number field frozen
	// Field only takes a write while no transmit flush is pending
	always @* begin
		txnum_nxt = txnum_r;
		if (wr_ctl && !tx_fl_r)
			txnum_nxt = reg_wdata_i[`URF_TXNUM_MSB:`URF_TXNUM_LSB];
	end

	// write one sets, hardware clears
	// Writing zero leaves a running operation alone
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			core_rst_r <= 1'b0;
		end else if (wr_ctl && reg_wdata_i[`URF_BIT_CORE_RST]) begin
			core_rst_r <= 1'b1;
		end else if (core_done) begin
			core_rst_r <= 1'b0;
		end
	end

	// clears control bits
	// Other bits fall on core reset, even against a same-cycle write
	always @(posedge core_clk_i) begin
		if (any_rst) begin
			bus_rst_r <= 1'b0;
			frm_rst_r <= 1'b0;
			rx_fl_r   <= 1'b0;
			tx_fl_r   <= 1'b0;
			txnum_r   <= 5'h00;
		end else begin
			txnum_r <= txnum_nxt;
			if (wr_ctl && reg_wdata_i[`URF_BIT_BUS_RST])
				bus_rst_r <= 1'b1;
			else if (bus_done)
				bus_rst_r <= 1'b0;
			// host mode only
			// Ignored in device mode; done in one cycle
			if (wr_ctl && reg_wdata_i[`URF_BIT_FRM_RST] && host_mode)
				frm_rst_r <= 1'b1;
			else
				frm_rst_r <= 1'b0;
			if (wr_ctl && reg_wdata_i[`URF_BIT_RX_FLUSH])
				rx_fl_r <= 1'b1;
			else if (rx_done)
				rx_fl_r <= 1'b0;
			if (wr_ctl && reg_wdata_i[`URF_BIT_TX_FLUSH])
				tx_fl_r <= 1'b1;
			else if (tx_done)
				tx_fl_r <= 1'b0;
		end
	end

	// kept bits survive
	// Only the chip reset clears the kept clock and speed bits
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			kept_gate_r <= 1'b0;
			kept_stop_r <= 1'b0;
			kept_phy_r  <= 2'h0;
			kept_spd_r  <= 2'h0;
		end else if (wr_kept) begin
			kept_gate_r <= reg_wdata_i[`URF_BIT_CLK_GATE];
			kept_stop_r <= reg_wdata_i[`URF_BIT_CLK_STOP];
			kept_phy_r  <= reg_wdata_i[`URF_PHYSEL_MSB:`URF_PHYSEL_LSB];
			kept_spd_r  <= reg_wdata_i[`URF_SPDSEL_MSB:`URF_SPDSEL_LSB];
		end
	end

	// host and device flush targets
	// Bit 16 stands for periodic in host mode; all-code selects every FIFO of the current mode
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			tx_sel_r <= 17'h0_0000;
		end else if (core_busy) begin
			tx_sel_r <= 17'h1_FFFF;
		end else if (tx_busy) begin
			// All-code hits only the FIFOs that exist in the current mode
			if (txnum_r == `URF_TXNUM_ALL && host_mode)
				tx_sel_r <= 17'h1_0001;
			else if (txnum_r == `URF_TXNUM_ALL)
				tx_sel_r <= 17'h0_FFFF;
			else if (host_mode && txnum_r == `URF_TXNUM_PER)
				tx_sel_r <= 17'h1_0000;
			else if (host_mode && txnum_r == `URF_TXNUM_NPER)
				tx_sel_r <= 17'h0_0001;
			else if (!host_mode && !txnum_r[4])
				tx_sel_r <= 17'h0_0001 << txnum_r[3:0];
			else
				tx_sel_r <= 17'h0_0000;
		end else begin
			tx_sel_r <= 17'h0_0000;
		end
	end

	// USB abort at once
	// Abort is raised two cycles after core reset is written
	always @(posedge core_clk_i) begin
		if (srst_i)
			usb_ab_r <= 1'b0;
		else
			usb_ab_r <= core_rst_r && usb_act_s;
	end

	assign mst_idle = !bus_act_s && !bus_busy;

	// Read data registered one cycle after strobe; unmapped reads zero
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
			`URF_OFS_RSTCTL: reg_rdata_o <= {mst_idle, 20'h0_0000, txnum_r, tx_fl_r,
				rx_fl_r, 1'b0, frm_rst_r, bus_rst_r, core_rst_r};
			`URF_OFS_MODE: reg_rdata_o <= {31'h0000_0000, host_mode};
			`URF_OFS_KEPT: reg_rdata_o <= {26'h000_0000, kept_spd_r, kept_phy_r,
				kept_stop_r, kept_gate_r};
			default: reg_rdata_o <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata_o <= 32'h0000_0000;
		end
	end

	assign slave_idle_o    = core_busy;
	assign bus_quiesce_o   = core_busy;
	assign phy_dom_rst_o   = core_busy;
	assign bus_dom_rst_o   = core_busy || bus_busy;
	assign usb_abort_o     = usb_ab_r;
	assign frame_cnt_clr_o = frm_rst_r || core_busy;
	assign rx_flush_o      = rx_busy || core_busy;
	assign tx_flush_o      = tx_sel_r;
	assign clk_gate_o      = kept_gate_r;
	assign clk_stop_o      = kept_stop_r;
	assign phy_clk_sel_o   = kept_phy_r;
	assign spd_sel_o       = kept_spd_r;
endmodule // urf_core
`default_nettype wire

// *** tb/urf_core_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
// Port-level checks on the reset and flush control
module urf_chk (
	input wire logic        core_clk_i, srst_i, reg_wr_i, reg_rd_i, host_mode_pin_i,
	input wire logic        bus_xfer_act_i, usb_xact_act_i, usb_abort_o, bus_quiesce_o,
	input wire logic        slave_idle_o, bus_dom_rst_o, phy_dom_rst_o, frame_cnt_clr_o,
	input wire logic        rx_flush_o, clk_gate_o, clk_stop_o,
	input wire logic [7:0]  reg_addr_i,
	input wire logic [31:0] reg_wdata_i, reg_rdata_o,
	input wire logic [16:0] tx_flush_o,
	input wire logic [1:0]  phy_clk_sel_o, spd_sel_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	// Control register write decode
	wire ctl_wr = reg_wr_i && reg_addr_i == 8'h10;
	chk_rx_start: assert property (
		ctl_wr && reg_wdata_i[4] && !rx_flush_o |-> ##[1:3] rx_flush_o) else $error("rx no start");
	chk_rx_length: assert property (
		$rose(rx_flush_o) |-> rx_flush_o[*8]) else $error("rx flush short");
	chk_tx_bounded: assert property (
		$rose(|tx_flush_o) && !phy_dom_rst_o |-> ##[6:12] tx_flush_o == 17'h0)
		else $error("tx flush stuck");
	chk_core_group: assert property (
		slave_idle_o == phy_dom_rst_o && bus_quiesce_o == phy_dom_rst_o)
		else $error("core outputs split");
	chk_core_covers: assert property (
		$rose(phy_dom_rst_o) |-> ##[0:1] (bus_dom_rst_o && rx_flush_o && frame_cnt_clr_o))
		else $error("core reset partial");
	chk_usb_abort: assert property (
		(phy_dom_rst_o && usb_xact_act_i)[*4] |-> usb_abort_o) else $error("usb not aborted");
	chk_abort_cause: assert property (
		usb_abort_o |-> phy_dom_rst_o || $past(phy_dom_rst_o)) else $error("stray abort");
	chk_core_waits: assert property (
		$fell(phy_dom_rst_o) |-> !$past(bus_xfer_act_i)) else $error("core ended mid transfer");
	chk_frame_dev: assert property (
		ctl_wr && reg_wdata_i == 32'h0000_0004 && !phy_dom_rst_o && !host_mode_pin_i
		&& $past(host_mode_pin_i, 3) == 1'b0 |-> ##1 (!frame_cnt_clr_o)[*3])
		else $error("frame clear in device mode");
	chk_frame_host: assert property (
		ctl_wr && reg_wdata_i[2] && host_mode_pin_i && $past(host_mode_pin_i, 3)
		|-> ##[1:3] frame_cnt_clr_o) else $error("frame clear missing");
	chk_rdata_gap: assert property (
		!$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000) else $error("read data outside slot");
endmodule // urf_chk
bind urf_core urf_chk urf_chk_i (.*);
`default_nettype wire

// *** tb/urf_far_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// Bus master and USB link activity seen by the block
module urf_far (
	input  wire logic core_clk_i,     // Clock
	input  wire logic srst_i,         // Sync reset
	input  wire logic bus_go_i,       // Start a bus burst
	input  wire logic usb_go_i,       // Start a USB transaction
	input  wire logic bus_quiesce_o,  // Block asks bus to wind down
	input  wire logic usb_abort_o,    // Block aborts USB traffic
	output logic      bus_xfer_act_i, // Bus burst in flight
	output logic      usb_xact_act_i  // USB transaction in flight
);
	logic [4:0] beat_r;
	// burst runs to its end
	// A started burst is never cut short; no new one under quiesce
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			beat_r <= 5'h00;
			bus_xfer_act_i <= 1'b0;
		end else if (beat_r != 5'h00) begin
			beat_r <= beat_r - 5'h01;
			bus_xfer_act_i <= beat_r != 5'h01;
		end else if (bus_go_i && !bus_quiesce_o) begin
			beat_r <= 5'h14;
			bus_xfer_act_i <= 1'b1;
		end
	end
	always @(posedge core_clk_i) begin
		if (srst_i || usb_abort_o) usb_xact_act_i <= 1'b0;
		else if (usb_go_i) usb_xact_act_i <= 1'b1;
	end
endmodule // urf_far
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	typedef struct packed { logic wr; logic [7:0] a; logic [31:0] d; } urf_row_t;
	logic        core_clk_i, srst_i, reg_wr_i, reg_rd_i, host_mode_pin_i, bus_go_i, usb_go_i;
	logic [7:0]  reg_addr_i;
	logic [31:0] reg_wdata_i, v;
	logic [16:0] seen;
	wire         usb_abort_o, bus_quiesce_o, slave_idle_o, bus_dom_rst_o, phy_dom_rst_o;
	wire         frame_cnt_clr_o, rx_flush_o, clk_gate_o, clk_stop_o, bus_xfer_act_i, usb_xact_act_i;
	wire  [31:0] reg_rdata_o;
	wire  [16:0] tx_flush_o;
	wire  [1:0]  phy_clk_sel_o, spd_sel_o;
	int          failures = 0, tests_run = 0, i, n;
	// Plain register accesses: write rows, or reads with expected data
	urf_row_t rows [9] = '{
		'{1'b0, 8'h10, 32'h8000_0000}, '{1'b1, 8'h10, 32'h0000_0000},
		'{1'b0, 8'h10, 32'h8000_0000}, '{1'b1, 8'h10, 32'h0000_0140},
		'{1'b0, 8'h10, 32'h8000_0140}, '{1'b1, 8'h44, 32'h0000_003F},
		'{1'b0, 8'h44, 32'h0000_003F}, '{1'b0, 8'h40, 32'h0000_0000},
		'{1'b0, 8'h24, 32'h0000_0000}};
	// Flush codes, device mode first, and the FIFOs each should hit
	logic [4:0]  codes [7] = '{5'h00, 5'h01, 5'h0F, 5'h10, 5'h00, 5'h01, 5'h10};
	logic [16:0] masks [7] = '{17'h0_0001, 17'h0_0002, 17'h0_8000, 17'h0_FFFF,
		17'h0_0001, 17'h1_0000, 17'h1_0001};
	urf_core urf_core_i (.*);
	urf_far  urf_far_i (.*);
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask
	// Self-clearing bits: bounded poll, a stuck bit fails
	task automatic poll(input int b);
		n = 0;
		do begin
			rd(8'h10, v);
			n++;
		end while (v[b] && n < 40);
		chk("bit clears", 0, v[b]);
	endtask
	task automatic end_of_test;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end
	// Whole run is under 300 cycles; this is over thirty times that
	initial begin
		#100000;
		failures++;
		end_of_test;
	end
	initial begin
		{srst_i, reg_wr_i, reg_rd_i, host_mode_pin_i, bus_go_i, usb_go_i} = 6'b10_0000;
		reg_addr_i = 8'h00;
		reg_wdata_i = 32'h0000_0000;
		repeat (16) @(posedge core_clk_i);
		srst_i <= 1'b0;
		for (i = 0; i < 9; i++) begin
			if (rows[i].wr) wr(rows[i].a, rows[i].d);
			else begin
				rd(rows[i].a, v);
				chk("table read", rows[i].d, v);
			end
		end
		chk("kept outs", 6'h3F, {spd_sel_o, phy_clk_sel_o, clk_stop_o, clk_gate_o});
		$display("table done");
		wr(8'h10, 32'h0000_0150);
		rd(8'h10, v);
		chk("rx bit set", 1, v[4]);
		chk("rx flush out", 1, rx_flush_o);
		poll(4);
		$display("rx flush done");
		for (i = 0; i < 7; i++) begin
			host_mode_pin_i <= (i > 3);
			repeat (4) @(posedge core_clk_i);
			wr(8'h10, {21'h0, codes[i], 6'h20});
			wr(8'h10, {21'h0, ~codes[i], 6'h00});
			n = 0;
			#1;
			while (tx_flush_o === 17'h0 && n < 10) begin
				@(posedge core_clk_i);
				#1 n++;
			end
			chk("tx target", masks[i], tx_flush_o);
			poll(5);
			rd(8'h10, v);
			chk("field kept", codes[i], v[10:6]);
			wr(8'h10, 32'h0000_0004);
			seen = 17'h0;
			repeat (4) begin
				#1 seen[0] = seen[0] | frame_cnt_clr_o;
				@(posedge core_clk_i);
			end
			chk("frame clear", i > 3, seen[0]);
			$display("tx code %0d done", i);
		end
		// core reset after clock select change
		wr(8'h44, 32'h0000_0035);
		bus_go_i <= 1'b1;
		usb_go_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		bus_go_i <= 1'b0;
		usb_go_i <= 1'b0;
		wr(8'h10, 32'h0000_0141);
		n = 0;
		while (usb_xact_act_i && n < 8) begin
			@(posedge core_clk_i);
			#1 n++;
		end
		chk("usb aborted", 0, usb_xact_act_i);
		chk("core flush", 2'b11, {rx_flush_o, slave_idle_o});
		poll(0);
		rd(8'h44, v);
		chk("kept after core", 32'h0000_0035, v);
		rd(8'h10, v);
		chk("ctl after core", 32'h8000_0000, v);
		$display("core reset done");
		wr(8'h10, 32'h0000_0002);
		rd(8'h10, v);
		chk("bus rst bit", 1, v[1]);
		chk("bus only", 2'b10, {bus_dom_rst_o, rx_flush_o});
		poll(1);
		$display("bus reset done");
		// Reset in the middle of a flush
		wr(8'h10, 32'h0000_0010);
		srst_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		srst_i <= 1'b0;
		repeat (3) @(posedge core_clk_i);
		rd(8'h10, v);
		chk("ctl after reset", 32'h8000_0000, v);
		chk("rx stopped", 0, rx_flush_o);
		$display("mid reset done");
		end_of_test;
	end
endmodule // tb_top
`default_nettype wire
